// [core/wdt_top.sv]
// Summary of operation
// - 32-bit counter counts down from load value
// - first time-out raises interrupt when enabled
// - unserviced second time-out asserts system reset
// - time-out may be routed as non-maskable
// - lock blocks configuration writes until unlocked
// - counter ticks from hclk divided by CLK_DIV, with enable
// - software bit enables reset generation
// - interrupt mask suppresses ordinary interrupt
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int CLK_DIV = 1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic wdt_irq,
  output logic wdt_nmi,
  output logic wdt_sys_rst
);

  localparam int DIV_W = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(CLK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  typedef struct packed
  {
    logic wr_pend;
    logic [OFF_W-1:0] wr_off;
    logic [CNT_W-1:0] load;
    logic [CTL_W-1:0] ctrl;
    logic raw;
    logic sys_rst;
    logic locked;
    logic [DIV_W-1:0] presc;
    logic [31:0] rdata;
  } wdt_top_s;

  wdt_top_s st_q;
  wdt_top_s st_d;

  wdt_cnt_if #(.W(CNT_W)) cnt_bus ();

  // counter sits in its own module so its width can change on its own
  wdt_count #(.W(CNT_W)) u_count
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .cnt(cnt_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic addr_ph;
  logic wr_load;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_lock;
  logic tick;
  logic irq_lvl;
  logic nmi_lvl;
  logic [CNT_W-1:0] load_next;
  logic rd_ph;
  logic second_hit;

  // only NONSEQ and SEQ are taken; IDLE and BUSY pass by
  assign addr_ph = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign rd_ph = addr_ph && !hwrite;
  // configuration writes are dropped silently while locked
  assign wr_load = st_q.wr_pend && (st_q.wr_off == OFF_LOAD) && !st_q.locked;
  assign wr_ctrl = st_q.wr_pend && (st_q.wr_off == OFF_CTRL) && !st_q.locked;
  // service stays open while locked so a running guard can be fed
  assign wr_clear = st_q.wr_pend && (st_q.wr_off == OFF_CLEAR);
  // lock itself stays writable, else it could never be opened again
  assign wr_lock = st_q.wr_pend && (st_q.wr_off == OFF_LOCK);

  ////////////////////////////////////////////////////////////////////////
  // watchdog tick and outputs

  // one tick per CLK_DIV hclk cycles while enabled
  assign tick = st_q.ctrl[CTL_CLKEN] && (st_q.presc == DIV_ZERO);

  // both follow raw status, so a service drops them at once
  // ordinary interrupt obeys the mask, the non-maskable one does not
  assign irq_lvl = st_q.raw && st_q.ctrl[CTL_INTEN] && !st_q.ctrl[CTL_NMI];
  assign nmi_lvl = st_q.raw && st_q.ctrl[CTL_NMI];

  // a time-out while the first is still unserviced is the second one
  assign second_hit = cnt_bus.timeout && st_q.raw && st_q.ctrl[CTL_RESEN];

  ////////////////////////////////////////////////////////////////////////
  // counter feed

  // a load write restarts the count from the word being written; the
  // stored load only changes at that same edge, so it would be stale
  assign load_next = wr_load ? hwdata[CNT_W-1:0] : st_q.load;
  assign cnt_bus.load_val = load_next;
  // service reloads too, so a fed guard gets a full period again
  assign cnt_bus.reload = wr_load || wr_clear;
  assign cnt_bus.tick = tick;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d = st_q;
    // write data arrives one cycle behind its address phase
    st_d.wr_pend = addr_ph && hwrite;
    if (addr_ph)
    begin
      st_d.wr_off = haddr[OFF_W-1:0];
    end

    if (wr_load)
    begin
      st_d.load = hwdata[CNT_W-1:0];
    end
    if (wr_ctrl)
    begin
      st_d.ctrl = hwdata[CTL_W-1:0];
    end
    // any word but the key locks, so a stray write fails safe
    if (wr_lock)
    begin
      st_d.locked = (hwdata != UNLOCK_KEY);
    end

    // watchdog clock divider, reloaded to DIV_TOP while the enable is off
    // reloading while off keeps the first tick a whole division away
    if (!st_q.ctrl[CTL_CLKEN] || st_q.presc == DIV_ZERO)
    begin
      st_d.presc = DIV_TOP;
    end
    else
    begin
      st_d.presc = st_q.presc - DIV_ONE;
    end

    if (wr_clear)
    begin
      st_d.raw = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (cnt_bus.timeout)
    begin
      st_d.raw = 1'b1;
      if (second_hit)
      begin
        st_d.sys_rst = 1'b1;
      end
    end

    // read data stands for its data phase only, zero otherwise
    st_d.rdata = RD_ZERO;
    if (rd_ph)
    begin
      unique case (haddr[OFF_W-1:0])
        OFF_LOAD: st_d.rdata = 32'(st_q.load);
        // count as it stood at the address phase
        OFF_VALUE: st_d.rdata = 32'(cnt_bus.value);
        OFF_CTRL: st_d.rdata = 32'(st_q.ctrl);
        OFF_RAW: st_d.rdata = 32'(st_q.raw);
        OFF_MASKED: st_d.rdata = 32'(irq_lvl || nmi_lvl);
        OFF_LOCK: st_d.rdata = 32'(st_q.locked);
        default: st_d.rdata = RD_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // load and counter both leave reset at all ones, so a guard
      // enabled without a load write gets the longest first period
      st_q <= '{
        wr_pend: 1'b0,
        wr_off: OFF_LOAD,
        load: LOAD_RST[CNT_W-1:0],
        ctrl: CTL_RST,
        raw: 1'b0,
        sys_rst: 1'b0,
        locked: 1'b0,
        presc: DIV_ZERO,
        rdata: RD_ZERO
      };
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // zero wait states, so every transfer completes OKAY in one data phase
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = st_q.rdata;
  assign wdt_irq = irq_lvl;
  assign wdt_nmi = nmi_lvl;
  // sticky until hresetn; the reset it raises is meant to pull that low
  assign wdt_sys_rst = st_q.sys_rst;

endmodule

// [core/wdt_pkg.sv]
package wdt_pkg;

  // register byte offsets, decoded from haddr[7:0]
  localparam int OFF_W = 8;
  localparam logic [7:0] OFF_LOAD = 8'h00;
  localparam logic [7:0] OFF_VALUE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_MASKED = 8'h14;
  localparam logic [7:0] OFF_LOCK = 8'h18;

  // control register fields
  localparam int CTL_W = 4;
  localparam int CTL_INTEN = 0;
  localparam int CTL_RESEN = 1;
  localparam int CTL_NMI = 2;
  localparam int CTL_CLKEN = 3;
  localparam logic [3:0] CTL_RST = 4'h0;

  localparam logic [31:0] LOAD_RST = 32'hFFFF_FFFF;
  // unlock key value is arbitrary
  localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551;

  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

// [core/wdt_cnt_if.sv]
`timescale 1ns/1ps
interface wdt_cnt_if #(parameter int W = 32);
  logic [W-1:0] load_val;
  logic reload;
  logic tick;
  logic [W-1:0] value;
  logic timeout;

  modport ctl
  (
    output load_val,
    output reload,
    output tick,
    input value,
    input timeout
  );

  modport cnt
  (
    input load_val,
    input reload,
    input tick,
    output value,
    output timeout
  );
endinterface

// [core/wdt_count.sv]
`timescale 1ns/1ps
module wdt_count
  import wdt_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic hclk,
  input wire logic hresetn,
  wdt_cnt_if.cnt cnt
);

  typedef struct packed
  {
    logic [W-1:0] value;
    logic timeout;
  } wdt_cnt_s;

  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] ONE = W'(1);

  wdt_cnt_s st_q;
  wdt_cnt_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.timeout = 1'b0;
    if (cnt.reload)
    begin
      st_d.value = cnt.load_val;
    end
    else if (cnt.tick)
    begin
      if (st_q.value == ZERO)
      begin
        // reload at time-out so the next one is a full period away
        st_d.value = cnt.load_val;
        st_d.timeout = 1'b1;
      end
      else
      begin
        st_d.value = st_q.value - ONE;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '{value: LOAD_RST[W-1:0], timeout: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt.value = st_q.value;
  assign cnt.timeout = st_q.timeout;

endmodule

// [tb/wdt_chk.sv]
`timescale 1ns/1ps
module wdt_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic wdt_irq,
  input wire logic wdt_nmi,
  input wire logic wdt_sys_rst
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr;
  logic rd;
  logic pend;
  assign wr = hsel && htrans[1] && hwrite;
  assign rd = hsel && htrans[1] && !hwrite;
  assign pend = wdt_irq || wdt_nmi;
  sequence rst_rise_s;
    $rose(wdt_sys_rst);
  endsequence
  ready_high_a: assert property (hreadyout) else $error("ready low");
  resp_okay_a: assert property (!hresp) else $error("resp not okay");
  rd_idle_a: assert property (!$past(rd) |-> hrdata == 32'h0000_0000) else $error("rdata");
  rst_sticky_a: assert property (wdt_sys_rst |=> wdt_sys_rst) else $error("rst dropped");
  irq_nmi_a: assert property (!(wdt_irq && wdt_nmi)) else $error("irq and nmi");
  irq_fall_a: assert property ($fell(wdt_irq) |-> $past(wr, 2)) else $error("irq fell");
  nmi_fall_a: assert property ($fell(wdt_nmi) |-> $past(wr, 2)) else $error("nmi fell");
  rst_cause_a: assert property (rst_rise_s |-> $past(pend)) else $error("rst early");
endmodule
bind wdt_top wdt_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout, .hresp,
  .hrdata, .wdt_irq, .wdt_nmi, .wdt_sys_rst);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb
  import wdt_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, r, v;
  logic [1:0] htrans;
  logic [2:0] hsize = HSIZE_WORD;
  wire logic hready, hreadyout, hresp, wdt_irq, wdt_nmi, wdt_sys_rst;
  wire logic [31:0] hrdata;
  wire logic [2:0] outs = {wdt_sys_rst, wdt_nmi, wdt_irq};
  int checked, n_mismatch, cyc, n, L, c;
  assign hready = hreadyout;
  wdt_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .wdt_irq, .wdt_nmi, .wdt_sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // read data taken at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_hi(input int i);
    for (n = 0; outs[i] !== 1'b1 && n < 400; n++) @(posedge hclk);
  endtask
  function automatic logic near(input int e);
    return n >= e - 3 && n <= e + 3;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    void'($urandom(20932));
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    xfer(0, OFF_LOAD, 0);
    cmp("load", LOAD_RST, r);
    xfer(0, OFF_CTRL, 0);
    cmp("ctrl", CTL_RST, r);
    repeat (3)
    begin
      v = $urandom;
      xfer(1, OFF_LOAD, v);
      xfer(0, OFF_LOAD, 0);
      cmp("load", v, r);
    end
    xfer(0, OFF_VALUE, 0);
    cmp("value", v, r);
    xfer(1, OFF_LOCK, 0);
    xfer(1, OFF_LOAD, 32'h0000_0005);
    xfer(0, OFF_LOAD, 0);
    cmp("locked load", v, r);
    xfer(1, OFF_LOCK, UNLOCK_KEY);
    xfer(0, OFF_LOCK, 0);
    cmp("lock", 0, r);
    for (int m = 0; m < 3; m++)
    begin
      L = 16 + $urandom % 16;
      c = (1 << CTL_CLKEN) | ((m == 0) << CTL_INTEN) | ((m == 1) << CTL_NMI);
      xfer(1, OFF_CTRL, c);
      xfer(1, OFF_LOAD, L);
      wait_hi(m == 1);
      cmp("outs", m == 2 ? 0 : 1 << m, outs);
      if (m < 2)
      begin
        cmp("period", 1, near(L + 2));
        xfer(0, OFF_VALUE, 0);
        cmp("reload", 1, r <= L && r + 8 >= L);
      end
      xfer(0, OFF_RAW, 0);
      cmp("raw", 1, r);
      xfer(0, OFF_MASKED, 0);
      cmp("masked", m != 2, r);
      // set wins if a time-out meets the clear, so clear twice
      repeat (2) xfer(1, OFF_CLEAR, 0);
      xfer(0, OFF_RAW, 0);
      cmp("cleared", 0, r);
    end
    xfer(1, OFF_CTRL, (1 << CTL_CLKEN) | (1 << CTL_INTEN));
    wait_hi(2);
    cmp("no rst", 3'b001, outs);
    xfer(1, OFF_CTRL, (1 << CTL_CLKEN) | (1 << CTL_INTEN) | (1 << CTL_RESEN));
    wait_hi(2);
    cmp("rst", 1, n <= L + 6);
    end_of_test();
  end
endmodule
